// ---- logic/srf_defines.svh ----
// Address map, field positions and reset values of the standard register file
`ifndef SRF_DEFINES_SVH
`define SRF_DEFINES_SVH

`define SRF_PORT_LO 8'h00
`define SRF_PORT_HI 8'h03
`define SRF_GPS_LO 8'h04
`define SRF_GPS_HI 8'hEF
`define SRF_CTL_LO 8'hF0
`define SRF_WREG_NIBBLE 4'hE
`define SRF_PAIR_COUNT 118
`define SRF_PORT_ZERO_DATA 8'h00
`define SRF_PORT_ONE_DATA 8'h01
`define SRF_PORT_TWO_DATA 8'h02
`define SRF_PORT_THREE_DATA 8'h03
`define SRF_SERIAL_DATA_PORT 8'hF0
`define SRF_TIMER_MODE_CONTROL 8'hF1
`define SRF_TIMER_COUNTER_ONE 8'hF2
`define SRF_TIMER_ONE_PRESCALER 8'hF3
`define SRF_TIMER_COUNTER_ZERO 8'hF4
`define SRF_TIMER_ZERO_PRESCALER 8'hF5
`define SRF_PORT_TWO_MODE 8'hF6
`define SRF_PORT_THREE_MODE 8'hF7
`define SRF_PORT_ZERO_ONE_MODE 8'hF8
`define SRF_INTERRUPT_PRIORITY 8'hF9
`define SRF_INTERRUPT_REQUEST 8'hFA
`define SRF_INTERRUPT_MASK 8'hFB
`define SRF_PROGRAM_CONTROL_FLAGS 8'hFC
`define SRF_REGISTER_POINTER 8'hFD
`define SRF_STACK_POINTER_HIGH 8'hFE
`define SRF_STACK_POINTER_LOW 8'hFF
`define SRF_RP_GROUP_MSB 7
`define SRF_RP_GROUP_LSB 4
`define SRF_CTL_RESET 8'h00
`define SRF_READ_FILL 8'hFF

`endif

// ---- logic/srf_pkg.sv ----
// Types shared by the standard register file modules
package srf_pkg;
	// Addressing mode of an operand
	typedef enum logic [1:0] {
		SRF_MODE_DIRECT = 2'h0,
		SRF_MODE_WORKING = 2'h1,
		SRF_MODE_INDIRECT = 2'h2,
		SRF_MODE_INDEXED = 2'h3
	} srf_mode_t;

	// Region that an address falls into
	typedef enum logic [2:0] {
		SRF_REGION_PORT = 3'h1,
		SRF_REGION_GPS = 3'h2,
		SRF_REGION_CTL = 3'h4
	} srf_region_t;
endpackage

// ---- logic/srf_decode_if.sv ----
// Address resolution signals between the register file and its decoder
`timescale 1ns/1ps
interface srf_decode_if;
	import srf_pkg::*;
	logic [7:0] operand;
	srf_mode_t mode;
	logic [7:0] base;
	logic word;
	logic [7:0] rp;
	logic [7:0] addr;
	srf_region_t region;
	logic legal;

	modport user (output operand, mode, base, word, rp, input addr, region, legal);
	modport decoder (input operand, mode, base, word, rp, output addr, region, legal);
endinterface

// ---- logic/srf_addr_decode.sv ----
// Operand address resolution for the standard register file
`timescale 1ns/1ps
`include "srf_defines.svh"
module srf_addr_decode
	import srf_pkg::*;
(
	srf_decode_if.decoder dif // Operand in, resolved address out
);
	// Classify an address into its region
	function automatic srf_region_t region_of(input logic [7:0] a);
		if (a <= `SRF_PORT_HI) begin
			region_of = SRF_REGION_PORT;
		end else if (a >= `SRF_CTL_LO) begin
			region_of = SRF_REGION_CTL;
		end else begin
			region_of = SRF_REGION_GPS;
		end
	endfunction

	logic [7:0] raw;

	// Form the effective address from the addressing mode
	always_comb begin
		raw = dif.operand;
		case (dif.mode)
			SRF_MODE_DIRECT: begin
				// High nibble E means a working register, not group E0-EF
				if (dif.operand[7:4] == `SRF_WREG_NIBBLE) begin
					raw = {dif.rp[`SRF_RP_GROUP_MSB:`SRF_RP_GROUP_LSB], dif.operand[3:0]};
				end
			end
			SRF_MODE_WORKING: begin
				raw = {dif.rp[`SRF_RP_GROUP_MSB:`SRF_RP_GROUP_LSB], dif.operand[3:0]};
			end
			SRF_MODE_INDIRECT: begin
				raw = dif.base;
			end
			SRF_MODE_INDEXED: begin
				raw = 8'(dif.base + dif.operand);
			end
			default: begin
				raw = dif.operand;
			end
		endcase
	end

	// Word accesses always start on the even register of a pair
	assign dif.addr = dif.word ? {raw[7:1], 1'b0} : raw;
	assign dif.region = region_of(dif.addr);
	assign dif.legal = 1'b1;
endmodule

// ---- logic/srf_gps_mem.sv ----
// General-purpose storage array, deliberately without reset
`timescale 1ns/1ps
`include "srf_defines.svh"
module srf_gps_mem #(
	parameter int DEPTH = 236 // Number of general-purpose registers
) (
	input wire logic clk_i, // System clock
	input wire logic [7:0] ra_i, // Read address A
	input wire logic [7:0] rb_i, // Read address B
	output logic [7:0] qa_o, // Read data A
	output logic [7:0] qb_o, // Read data B
	input wire logic we_hi_i, // Write enable, byte at wa_i
	input wire logic [7:0] wa_i, // Write address (even for words)
	input wire logic [7:0] wd_hi_i, // Byte written at wa_i
	input wire logic we_lo_i, // Write enable, byte at wa_i+1
	input wire logic [7:0] wd_lo_i // Byte written at wa_i+1
);
	logic [7:0] mem_r [DEPTH];
	logic [7:0] wa_lo;

	// Map a file address to an array index
	function automatic int idx(input logic [7:0] a);
		idx = int'(a) - int'(`SRF_GPS_LO);
	endfunction

	assign wa_lo = wa_i | 8'h01;
	assign qa_o = mem_r[idx(ra_i)];
	assign qb_o = mem_r[idx(rb_i)];

	// No reset: contents survive any reset in the operating supply range
	always_ff @(posedge clk_i) begin
		if (we_hi_i) begin
			mem_r[idx(wa_i)] <= wd_hi_i;
		end
		if (we_lo_i) begin
			mem_r[idx(wa_lo)] <= wd_lo_i;
		end
	end
endmodule

// ---- logic/srf_register_file.sv ----
// Standard register file: ports, general-purpose storage and control registers
//
// What this block does
// - Selects standard file space; expanded, program and data spaces lie outside.
// - Eight-bit address reaching up to 256 byte registers.
// - Ports at 00-03, general storage 04-EF, control registers F0-FF.
// - Byte and word access via direct, indirect or indexed addressing.
// - Every general register read and written by any byte instruction.
// - Word access uses even-odd pairs, 118 pairs in general storage.
// - High byte at even address, low byte at next odd address.
// - Source operands are read, the destination operand is written.
// - General storage has no reset and keeps contents through resets.
// - Group E0-EF is never reached by a direct eight-bit address.
// - Direct operand with high nibble E names a working register.
// - Working address is pointer high nibble joined with 4-bit field.
`timescale 1ns/1ps
`include "srf_defines.svh"
module srf_register_file
	import srf_pkg::*;
#(
	parameter int GPS_DEPTH = 236 // General-purpose registers
) (
	input wire logic clk_i, // System clock, 125 MHz
	input wire logic rst_n_i, // Asynchronous reset, active low
	input wire logic space_std_i, // Access targets the standard file
	input wire logic [7:0] src_opnd_i, // Source operand field
	input wire srf_mode_t src_mode_i, // Source addressing mode
	input wire logic [7:0] src_base_i, // Source indirect/index base
	input wire logic src_word_i, // Source is a word access
	output logic [15:0] src_data_o, // Source data, word in [15:0]
	input wire logic dst_we_i, // Destination write strobe
	input wire logic [7:0] dst_opnd_i, // Destination operand field
	input wire srf_mode_t dst_mode_i, // Destination addressing mode
	input wire logic [7:0] dst_base_i, // Destination indirect/index base
	input wire logic dst_word_i, // Destination is a word access
	input wire logic [15:0] dst_data_i, // Write data, high byte [15:8]
	input wire logic [31:0] port_in_i, // Port pin levels, port n at [8n+7:8n]
	output logic [31:0] port_out_o, // Port output latches
	output logic [7:0] register_pointer_o, // Current register pointer
	output logic [7:0] interrupt_mask_o, // Interrupt mask contents
	output logic [7:0] program_control_flags_o // Flag register contents
);
	//------------------------------------------------------------------
	// Address resolution
	//------------------------------------------------------------------
	srf_decode_if src_if();
	srf_decode_if dst_if();
	logic [7:0] rp_r;

	srf_addr_decode u_src_dec (
		.dif(src_if.decoder)
	);
	srf_addr_decode u_dst_dec (
		.dif(dst_if.decoder)
	);

	// Both operands resolve through the same register pointer
	always_comb begin
		src_if.operand = src_opnd_i;
		src_if.mode = src_mode_i;
		src_if.base = src_base_i;
		src_if.word = src_word_i;
		src_if.rp = rp_r;
		dst_if.operand = dst_opnd_i;
		dst_if.mode = dst_mode_i;
		dst_if.base = dst_base_i;
		dst_if.word = dst_word_i;
		dst_if.rp = rp_r;
	end

	//------------------------------------------------------------------
	// Helpers
	//------------------------------------------------------------------
	// Is the address a general-purpose register
	function automatic logic is_gps(input logic [7:0] a);
		is_gps = (a >= `SRF_GPS_LO) && (a <= `SRF_GPS_HI);
	endfunction

	// Index of a control register within F0-FF
	function automatic logic [3:0] ctl_idx(input logic [7:0] a);
		ctl_idx = a[3:0];
	endfunction

	//------------------------------------------------------------------
	// Port and control registers
	//------------------------------------------------------------------
	logic [7:0] port_r [4];
	logic [7:0] port_nxt [4];
	logic [7:0] ctl_r [16];
	logic [7:0] ctl_nxt [16];
	logic [7:0] wr_addr_hi;
	logic [7:0] wr_addr_lo;
	logic wr_en;

	// Word writes hit the pair; byte writes use the low half of the data
	assign wr_en = dst_we_i && space_std_i;
	assign wr_addr_hi = dst_if.addr;
	assign wr_addr_lo = dst_if.addr | 8'h01;

	// Next-state for ports and control registers, one pass per byte lane
	always_comb begin
		for (int i = 0; i < 4; i++) begin
			port_nxt[i] = port_r[i];
		end
		for (int i = 0; i < 16; i++) begin
			ctl_nxt[i] = ctl_r[i];
		end
		if (wr_en) begin
			if (dst_word_i) begin
				if (dst_if.region == SRF_REGION_PORT) begin
					port_nxt[wr_addr_hi[1:0]] = dst_data_i[15:8];
					port_nxt[wr_addr_lo[1:0]] = dst_data_i[7:0];
				end else if (dst_if.region == SRF_REGION_CTL) begin
					ctl_nxt[ctl_idx(wr_addr_hi)] = dst_data_i[15:8];
					ctl_nxt[ctl_idx(wr_addr_lo)] = dst_data_i[7:0];
				end
			end else begin
				if (dst_if.region == SRF_REGION_PORT) begin
					port_nxt[wr_addr_hi[1:0]] = dst_data_i[7:0];
				end else if (dst_if.region == SRF_REGION_CTL) begin
					ctl_nxt[ctl_idx(wr_addr_hi)] = dst_data_i[7:0];
				end
			end
		end
	end

	// Ports and control registers take a defined value at reset
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			for (int i = 0; i < 4; i++) begin
				port_r[i] <= `SRF_CTL_RESET;
			end
			for (int i = 0; i < 16; i++) begin
				ctl_r[i] <= `SRF_CTL_RESET;
			end
		end else begin
			port_r <= port_nxt;
			ctl_r <= ctl_nxt;
		end
	end

	assign rp_r = ctl_r[ctl_idx(`SRF_REGISTER_POINTER)];

	//------------------------------------------------------------------
	// General-purpose storage
	//------------------------------------------------------------------
	logic [7:0] gps_qa;
	logic [7:0] gps_qb;
	logic gps_we_hi;
	logic gps_we_lo;
	logic [7:0] gps_wd_hi;
	logic [7:0] src_addr_lo;

	// Any byte write reaches any general register; no special path
	assign gps_we_hi = wr_en && is_gps(wr_addr_hi);
	assign gps_we_lo = wr_en && dst_word_i && is_gps(wr_addr_lo);
	assign gps_wd_hi = dst_word_i ? dst_data_i[15:8] : dst_data_i[7:0];
	assign src_addr_lo = src_if.addr | 8'h01;

	srf_gps_mem #(
		.DEPTH(GPS_DEPTH)
	) u_gps (
		.clk_i(clk_i),
		.ra_i(src_if.addr),
		.rb_i(src_addr_lo),
		.qa_o(gps_qa),
		.qb_o(gps_qb),
		.we_hi_i(gps_we_hi),
		.wa_i(wr_addr_hi),
		.wd_hi_i(gps_wd_hi),
		.we_lo_i(gps_we_lo),
		.wd_lo_i(dst_data_i[7:0])
	);

	//------------------------------------------------------------------
	// Source read path
	//------------------------------------------------------------------
	// Read one byte from any region
	function automatic logic [7:0] rd_byte(
		input logic [7:0] a,
		input logic [7:0] gq,
		input logic [31:0] pins,
		input logic [7:0] ctl [16]
	);
		if (a <= `SRF_PORT_HI) begin
			rd_byte = pins[a[1:0]*8 +: 8];
		end else if (a >= `SRF_CTL_LO) begin
			rd_byte = ctl[a[3:0]];
		end else begin
			rd_byte = gq;
		end
	endfunction

	logic [7:0] src_hi;
	logic [7:0] src_lo;

	// Source operands are read combinationally from the resolved address
	always_comb begin
		src_hi = rd_byte(src_if.addr, gps_qa, port_in_i, ctl_r);
		src_lo = rd_byte(src_addr_lo, gps_qb, port_in_i, ctl_r);
		if (!space_std_i) begin
			src_data_o = {`SRF_READ_FILL, `SRF_READ_FILL};
		end else if (src_word_i) begin
			src_data_o = {src_hi, src_lo};
		end else begin
			src_data_o = {8'h00, src_hi};
		end
	end

	//------------------------------------------------------------------
	// Outputs
	//------------------------------------------------------------------
	// Port latches drive the pins; pin levels are read back
	always_comb begin
		for (int i = 0; i < 4; i++) begin
			port_out_o[i*8 +: 8] = port_r[i];
		end
	end

	assign register_pointer_o = rp_r;
	assign interrupt_mask_o = ctl_r[ctl_idx(`SRF_INTERRUPT_MASK)];
	assign program_control_flags_o = ctl_r[ctl_idx(`SRF_PROGRAM_CONTROL_FLAGS)];
endmodule

// ---- verification/srf_register_file_sva.sv ----
// Port-level checker for the standard register file
`timescale 1ns/1ps
module srf_register_file_sva
	import srf_pkg::*;
#(
	parameter int GPS_DEPTH = 236 // Storage depth
) (
	input wire logic clk_i, // Clock
	input wire logic rst_n_i, // Reset
	input wire logic space_std_i, // Space select
	input wire logic [7:0] src_opnd_i, // Src operand
	input wire srf_mode_t src_mode_i, // Src mode
	input wire logic [7:0] src_base_i, // Src base
	input wire logic src_word_i, // Src word
	input wire logic [15:0] src_data_o, // Read data
	input wire logic dst_we_i, // Write strobe
	input wire logic [7:0] dst_opnd_i, // Dst operand
	input wire srf_mode_t dst_mode_i, // Dst mode
	input wire logic [7:0] dst_base_i, // Dst base
	input wire logic dst_word_i, // Dst word
	input wire logic [15:0] dst_data_i, // Write data
	input wire logic [31:0] port_in_i, // Pins
	input wire logic [31:0] port_out_o, // Latches
	input wire logic [7:0] register_pointer_o, // Pointer
	input wire logic [7:0] interrupt_mask_o, // Mask
	input wire logic [7:0] program_control_flags_o // Flags
);
	// ------
	// Sequences and properties
	// ------
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!rst_n_i);
	// Direct byte write to one address
	sequence wdir(a);
		space_std_i && dst_we_i && dst_mode_i == SRF_MODE_DIRECT && !dst_word_i
			&& dst_opnd_i == a;
	endsequence
	// Word write inside storage, then word read of the same pair
	sequence wword;
		space_std_i && dst_we_i && dst_mode_i == SRF_MODE_DIRECT && dst_word_i
			&& dst_opnd_i[7:4] inside {[4'h1:4'hD]};
	endsequence
	sequence rsame;
		space_std_i && !dst_we_i && src_mode_i == SRF_MODE_DIRECT && src_word_i
			&& src_opnd_i[7:1] == $past(dst_opnd_i[7:1]);
	endsequence
	AST_WORD_RT: assert property (wword ##1 rsame |-> src_data_o == $past(dst_data_i))
		else $error("word pair read back differs");
	AST_RP_WR: assert property (wdir(8'hFD) |=> register_pointer_o == $past(dst_data_i[7:0]))
		else $error("pointer not written");
	AST_IMR_WR: assert property (wdir(8'hFB) |=> interrupt_mask_o == $past(dst_data_i[7:0]))
		else $error("mask not written");
	AST_FLG_WR: assert property (wdir(8'hFC) |=> program_control_flags_o == $past(dst_data_i[7:0]))
		else $error("flags not written");
	AST_PORT_WR: assert property (wdir(8'h02) |=> port_out_o[23:16] == $past(dst_data_i[7:0]))
		else $error("port latch not written");
	AST_PORT_RD: assert property (space_std_i && src_mode_i == SRF_MODE_DIRECT && !src_word_i
		&& src_opnd_i == 8'h01 |-> src_data_o == {8'h00, port_in_i[15:8]})
		else $error("port read wrong");
	// Both forms must land on the pointer while it names the top group
	AST_WREG_RD: assert property (space_std_i && !dst_we_i && !src_word_i
		&& register_pointer_o[7:4] == 4'hF && (src_mode_i == SRF_MODE_DIRECT && src_opnd_i == 8'hED
		|| src_mode_i == SRF_MODE_WORKING && src_opnd_i[3:0] == 4'hD)
		|-> src_data_o == {8'h00, register_pointer_o})
		else $error("working register read wrong");
	AST_FAR_RD: assert property (!space_std_i |-> src_data_o == 16'hFFFF)
		else $error("foreign read not all ones");
	AST_FAR_WR: assert property (!space_std_i && dst_we_i |=> $stable(register_pointer_o))
		else $error("foreign write landed");
endmodule

bind srf_register_file srf_register_file_sva #(.GPS_DEPTH(GPS_DEPTH)) u_sva (.clk_i(clk_i),
	.rst_n_i(rst_n_i), .space_std_i(space_std_i), .src_opnd_i(src_opnd_i),
	.src_mode_i(src_mode_i), .src_base_i(src_base_i), .src_word_i(src_word_i),
	.src_data_o(src_data_o), .dst_we_i(dst_we_i), .dst_opnd_i(dst_opnd_i),
	.dst_mode_i(dst_mode_i), .dst_base_i(dst_base_i), .dst_word_i(dst_word_i),
	.dst_data_i(dst_data_i), .port_in_i(port_in_i), .port_out_o(port_out_o),
	.register_pointer_o(register_pointer_o), .interrupt_mask_o(interrupt_mask_o),
	.program_control_flags_o(program_control_flags_o));

// ---- verification/srf_cpu_model.sv ----
// Execution datapath model that names sources and destinations
`timescale 1ns/1ps
module srf_cpu_model
	import srf_pkg::*;
(
	input wire logic clk_i, // Clock
	input wire logic [15:0] rdata_i, // Read data
	output srf_mode_t s_mode_o, // Src mode
	output logic [7:0] s_opnd_o, // Src operand
	output logic [7:0] s_base_o, // Src base
	output logic s_word_o, // Src word
	output logic we_o, // Write strobe
	output srf_mode_t d_mode_o, // Dst mode
	output logic [7:0] d_opnd_o, // Dst operand
	output logic [7:0] d_base_o, // Dst base
	output logic d_word_o, // Dst word
	output logic [15:0] d_data_o // Write data
);
	// ------
	// Operand tasks, entered at a falling edge
	// ------
	initial begin
		{s_opnd_o, s_base_o, s_word_o, we_o} = '0;
		{d_opnd_o, d_base_o, d_word_o, d_data_o} = '0;
		s_mode_o = SRF_MODE_DIRECT;
		d_mode_o = SRF_MODE_DIRECT;
	end
	// Destination write, taken at the next rising edge
	task automatic wr(input srf_mode_t m, input logic [7:0] a, b, input logic w,
		input logic [15:0] d);
		d_mode_o = m;
		d_opnd_o = a;
		d_base_o = b;
		d_word_o = w;
		d_data_o = d;
		we_o = 1'b1;
		// Strobe stays up for back-to-back writes; the next read lowers it
		@(negedge clk_i);
	endtask
	// Source read, sampled once the combinational path settles
	task automatic rd(input srf_mode_t m, input logic [7:0] a, b, input logic w,
		output logic [15:0] q);
		we_o = 1'b0;
		s_mode_o = m;
		s_opnd_o = a;
		s_base_o = b;
		s_word_o = w;
		#1 q = rdata_i;
		@(negedge clk_i);
	endtask
endmodule

// ---- verification/testbench.sv ----
// Directed testbench for the standard register file
`timescale 1ns/1ps
module testbench
	import srf_pkg::*;
;
	localparam srf_mode_t DIR = SRF_MODE_DIRECT;
	localparam srf_mode_t WRK = SRF_MODE_WORKING;
	localparam srf_mode_t IND = SRF_MODE_INDIRECT;
	localparam srf_mode_t IDX = SRF_MODE_INDEXED;
	logic clk, rst_n, std, s_word, we, d_word;
	logic [31:0] pin, pout;
	logic [15:0] q, rdat, d_data;
	logic [7:0] s_opnd, s_base, d_opnd, d_base, rp, interrupt_mask, flg;
	logic [7:0] ga [3] = '{8'h04, 8'h05, 8'hDF};
	srf_mode_t s_mode, d_mode;
	int miscompares, checked;

	srf_register_file dut (.clk_i(clk), .rst_n_i(rst_n), .space_std_i(std),
		.src_opnd_i(s_opnd), .src_mode_i(s_mode), .src_base_i(s_base), .src_word_i(s_word),
		.src_data_o(rdat), .dst_we_i(we), .dst_opnd_i(d_opnd), .dst_mode_i(d_mode),
		.dst_base_i(d_base), .dst_word_i(d_word), .dst_data_i(d_data), .port_in_i(pin),
		.port_out_o(pout), .register_pointer_o(rp), .interrupt_mask_o(interrupt_mask),
		.program_control_flags_o(flg));
	srf_cpu_model cpu (.clk_i(clk), .rdata_i(rdat), .s_mode_o(s_mode), .s_opnd_o(s_opnd),
		.s_base_o(s_base), .s_word_o(s_word), .we_o(we), .d_mode_o(d_mode),
		.d_opnd_o(d_opnd), .d_base_o(d_base), .d_word_o(d_word), .d_data_o(d_data));

	// ------
	// Compare and closing tasks
	// ------
	task automatic chk(input string n, input logic [15:0] g, e);
		checked++;
		if (g !== e) begin
			miscompares++;
			$display("[FAIL] %s exp %h got %h", n, e, g);
		end
	endtask
	task automatic rc(input string n, input srf_mode_t m, input logic [7:0] a, b,
		input logic w, input logic [15:0] e);
		cpu.rd(m, a, b, w, q);
		chk(n, q, e);
	endtask
	task end_sim;
		if (miscompares == 0 && checked > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask

	// Clock and hang guard, run needs about fifty cycles
	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end
	initial begin
		repeat (1000) @(posedge clk);
		miscompares++;
		end_sim;
	end

	// Main sequence
	initial begin
		rst_n = 1'b0;
		std = 1'b1;
		pin = 32'hA5C3_5A3C;
		miscompares = 0;
		checked = 0;
		repeat (4) @(posedge clk);
		@(negedge clk) rst_n = 1'b1;
		cpu.wr(DIR, 8'h20, 8'h00, 1'b1, 16'h1234);
		rc("word", DIR, 8'h21, 8'h00, 1'b1, 16'h1234);
		rc("hi", DIR, 8'h20, 8'h00, 1'b0, 16'h0012);
		rc("lo", DIR, 8'h21, 8'h00, 1'b0, 16'h0034);
		cpu.wr(DIR, 8'h31, 8'h00, 1'b1, 16'h5678);
		rc("odd", DIR, 8'h30, 8'h00, 1'b0, 16'h0056);
		for (int i = 0; i < 3; i++) begin
			cpu.wr(DIR, ga[i], 8'h00, 1'b0, {8'h00, ~ga[i]});
			rc("gps", DIR, ga[i], 8'h00, 1'b0, {8'h00, ~ga[i]});
		end
		cpu.wr(IND, 8'h00, 8'hEF, 1'b0, 16'h0011);
		cpu.wr(IND, 8'h00, 8'hE5, 1'b0, 16'h0022);
		for (int i = 0; i < 4; i++)
			rc("pin", DIR, 8'(i), 8'h00, 1'b0, {8'h00, pin[8*i+:8]});
		cpu.wr(DIR, 8'h02, 8'h00, 1'b0, 16'h005A);
		chk("pout", {8'h00, pout[23:16]}, 16'h005A);
		cpu.wr(DIR, 8'hFD, 8'h00, 1'b0, 16'h00F0);
		chk("rp", {8'h00, rp}, 16'h00F0);
		rc("wrk", WRK, 8'h0D, 8'h00, 1'b0, 16'h00F0);
		rc("dirE", DIR, 8'hED, 8'h00, 1'b0, 16'h00F0);
		cpu.wr(DIR, 8'hFD, 8'h00, 1'b0, 16'h0030);
		cpu.wr(WRK, 8'h02, 8'h00, 1'b0, 16'h0044);
		rc("wrk2", DIR, 8'h32, 8'h00, 1'b0, 16'h0044);
		cpu.wr(DIR, 8'hE5, 8'h00, 1'b0, 16'h0099);
		rc("dirE5", DIR, 8'h35, 8'h00, 1'b0, 16'h0099);
		rc("e5", IND, 8'h00, 8'hE5, 1'b0, 16'h0022);
		rc("ef", IND, 8'h00, 8'hEF, 1'b0, 16'h0011);
		cpu.wr(IDX, 8'h05, 8'h40, 1'b1, 16'hBEEF);
		rc("idx", DIR, 8'h44, 8'h00, 1'b1, 16'hBEEF);
		cpu.wr(IDX, 8'h20, 8'hF0, 1'b0, 16'h0066);
		rc("wrap", DIR, 8'h10, 8'h00, 1'b0, 16'h0066);
		cpu.wr(DIR, 8'hFB, 8'h00, 1'b0, 16'h00C3);
		chk("imr", {8'h00, interrupt_mask}, 16'h00C3);
		cpu.wr(DIR, 8'hFC, 8'h00, 1'b0, 16'h003C);
		chk("flg", {8'h00, flg}, 16'h003C);
		// Word pairs in the port and control regions, and an indexed read
		cpu.wr(DIR, 8'h01, 8'h00, 1'b1, 16'h1357);
		chk("pout01", pout[15:0], 16'h5713);
		cpu.wr(DIR, 8'h03, 8'h00, 1'b1, 16'h9ABC);
		chk("pout23", pout[31:16], 16'hBC9A);
		cpu.wr(DIR, 8'hFE, 8'h00, 1'b1, 16'h1A2B);
		rc("spw", DIR, 8'hFF, 8'h00, 1'b1, 16'h1A2B);
		rc("idxr", IDX, 8'h05, 8'h40, 1'b1, 16'hBEEF);
		// Other space: writes dropped, reads all ones
		std = 1'b0;
		cpu.wr(DIR, 8'hFD, 8'h00, 1'b0, 16'h00AA);
		chk("rp2", {8'h00, rp}, 16'h0030);
		rc("far", DIR, 8'h20, 8'h00, 1'b0, 16'hFFFF);
		std = 1'b1;
		// Mid-run reset clears control but not storage
		cpu.wr(DIR, 8'h50, 8'h00, 1'b0, 16'h00AB);
		rc("pre", DIR, 8'h50, 8'h00, 1'b0, 16'h00AB);
		rst_n = 1'b0;
		repeat (2) @(negedge clk);
		rst_n = 1'b1;
		chk("rp0", {8'h00, rp}, 16'h0000);
		chk("imr0", {8'h00, interrupt_mask}, 16'h0000);
		chk("plo0", pout[15:0], 16'h0000);
		chk("phi0", pout[31:16], 16'h0000);
		rc("keep", DIR, 8'h50, 8'h00, 1'b0, 16'h00AB);
		rc("keepw", DIR, 8'h20, 8'h00, 1'b1, 16'h1234);
		end_sim;
	end
endmodule
